// ---- masr_readout.sv ----
// top of the angle serial readout: serial word, daisy chain, pulse output,
// open-drain field flags and the one-time-programmable configuration path
// assumes pins arrive asynchronously; sensor inputs are on clk
`timescale 1ns/100ps
`default_nettype none

module masr_readout #(
   parameter int ABITS = masr_pkg::ANGLE_BITS,  // angle width
   parameter int OBITS = masr_pkg::OTP_BITS     // configuration chain length
) (
   // clock and reset
   input  wire logic                 clk,
   input  wire logic                 rst,
   // sensor results on clk
   input  wire logic [ABITS-1:0]     angle,
   input  wire logic                 offset_done,
   input  wire logic                 overflow,
   input  wire logic                 linearity_alarm,
   input  wire logic                 field_up,
   input  wire logic                 field_down,
   // serial pins from the host
   input  wire logic                 sclk,
   input  wire logic                 select_n,
   input  wire logic                 prog_in,
   input  wire logic                 prog_burn_level,
   input  wire logic                 speed_sel,
   // serial data pin
   output var  logic                 data_out,
   output var  logic                 data_oe_n,
   // open-drain field flags
   output var  logic                 field_up_flag_n_o,
   output var  logic                 field_up_flag_n_oe_n,
   output var  logic                 field_down_flag_n_o,
   output var  logic                 field_down_flag_n_oe_n,
   // pulse width output
   output var  logic                 pwm_out,
   // status
   output var  logic                 fast_mode,
   output var  logic                 quad_mode_en,
   output var  logic                 prog_mode,
   output var  logic                 fuses_done,
   output var  logic [masr_pkg::OTP_USER_BITS-1:0] otp_user,
   output var  logic [masr_pkg::DIE_ID_BITS-1:0]   unique_die_identifier
);

   // ==========================================================
   // local sizes
   localparam int FB = masr_pkg::FRAME_BITS;  // word plus separator
   localparam int CW = $clog2(OBITS + 1);     // fuse counter width

   // ==========================================================
   // elaboration checks
   if (ABITS != masr_pkg::ANGLE_BITS ||
       (2 ** ABITS) != masr_pkg::ANGLE_POSITIONS)
   begin : g_bad_angle
      $error("masr_readout angle width must give 4096 positions");
   end
   if (OBITS != masr_pkg::OTP_BITS)
   begin : g_bad_otp
      $error("masr_readout configuration chain must be 54 bits");
   end

   // ==========================================================
   // pin synchronisers
   logic sclk_s;     // synchronised serial clock
   logic sel_n_s;    // synchronised select, active low
   logic prog_s;     // synchronised programming input
   logic burn_s;     // synchronised burn level detect
   logic speed_s;    // synchronised speed select

   // select idles high, the others low, matching their pulls
   masr_sync #(
      .WIDTH   (5),
      .RST_VAL (5'h08)
   ) u_sync (
      .clk      (clk),
      .rst      (rst),
      .async_in ({sclk, select_n, prog_in, prog_burn_level, speed_sel}),
      .sync_out ({sclk_s, sel_n_s, prog_s, burn_s, speed_s})
   );

   // ==========================================================
   // edge detection on synchronised levels
   logic sclk_q;   // serial clock one cycle back
   logic sel_n_q;  // select one cycle back

   // history registers
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         sclk_q  <= 1'h0;
         sel_n_q <= 1'h1;
      end
      else
      begin
         sclk_q  <= sclk_s;
         sel_n_q <= sel_n_s;
      end
   end

   wire sclk_rise = sclk_s & ~sclk_q;     // host clock rising edge
   wire sel_fall  = ~sel_n_s & sel_n_q;   // host selects the device
   wire sel_rise  = sel_n_s & ~sel_n_q;   // host releases the device

   // ==========================================================
   // mode state
   masr_pkg::masr_mode_t mode;       // current mode
   masr_pkg::masr_mode_t next_mode;  // mode for the next cycle

   // programming entry needs prog high and clock low at select rise
   wire prog_entry = sel_rise & prog_s & ~sclk_s;

   // mode transitions; no path leads back to normal but reset
   always_comb
   begin
      next_mode = mode;
      case (mode)
         masr_pkg::MASR_NORMAL:
         begin
            if (prog_entry)
               next_mode = masr_pkg::MASR_PROG_LOAD;
         end
         masr_pkg::MASR_PROG_LOAD:
         begin
            if (burn_s)
               next_mode = masr_pkg::MASR_PROG_BURN;
         end
         masr_pkg::MASR_PROG_BURN:
         begin
            if (!burn_s)
               next_mode = masr_pkg::MASR_PROG_LOAD;
         end
         default:
         begin
            next_mode = masr_pkg::MASR_NORMAL;
         end
      endcase
   end

   // mode register, left only through reset
   always_ff @(posedge clk)
   begin
      if (rst)
         mode <= masr_pkg::MASR_NORMAL;
      else
         mode <= next_mode;
   end

   wire in_normal = (mode == masr_pkg::MASR_NORMAL);
   wire in_load   = (mode == masr_pkg::MASR_PROG_LOAD);
   wire in_burn   = (mode == masr_pkg::MASR_PROG_BURN);

   // ==========================================================
   // serial word assembly
   logic [masr_pkg::WORD_BITS-1:0] word;  // word as captured

   // place every field at its position, parity over the rest
   always_comb
   begin
      word = '0;
      word[masr_pkg::POS_ANGLE_LSB +: ABITS] = angle;
      word[masr_pkg::POS_OFFSET_DONE] = offset_done;
      word[masr_pkg::POS_OVERFLOW]    = overflow;
      word[masr_pkg::POS_LINEARITY]   = linearity_alarm;
      word[masr_pkg::POS_FIELD_UP]    = field_up;
      word[masr_pkg::POS_FIELD_DOWN]  = field_down;
      word[masr_pkg::POS_PARITY]      = ^word;
   end

   // ==========================================================
   // readout shift register and daisy chain
   logic [FB-1:0] frame;  // word, separator, then upstream data

   // load on select fall, shift on each host clock rise
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         frame <= '0;
      end
      else if (in_normal && sel_fall)
      begin
         frame <= {word, masr_pkg::SEP_VALUE};  // all fields at once
      end
      else if (in_normal && !sel_n_s && sclk_rise)
      begin
         frame <= {frame[FB-2:0], prog_s};  // upstream data follows
      end
   end

   // pin driver: data only while selected in normal mode
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         data_out  <= 1'h0;
         data_oe_n <= 1'h1;  // released at reset
      end
      else
      begin
         data_out  <= frame[FB-1];  // msb first
         data_oe_n <= sel_n_s | ~in_normal;
      end
   end

   // ==========================================================
   // configuration shift chain
   logic [OBITS-1:0] otp_shift;  // bits shifted in by the host

   // first bit ends in the top position after 54 clocks
   always_ff @(posedge clk)
   begin
      if (rst)
         otp_shift <= '0;
      else if (in_load && sclk_rise)
         otp_shift <= {otp_shift[OBITS-2:0], prog_s};
   end

   // ==========================================================
   // fuse array
   logic [OBITS-1:0] fuse = masr_pkg::FUSE_BLANK;  // survives reset
   logic [CW-1:0]    burn_cnt;                      // fuses blown so far
   wire              burn_go  = in_burn & sclk_rise & (burn_cnt != CW'(OBITS));
   wire  [CW-1:0]    burn_pos = CW'(OBITS - 1) - burn_cnt;  // top fuse first

   // one fuse per host clock while the burn level is present
   always_ff @(posedge clk)
   begin
      if (burn_go)
         fuse[burn_pos] <= otp_shift[burn_pos];
   end

   // burn progress
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         burn_cnt   <= '0;
         fuses_done <= 1'h0;
      end
      else
      begin
         if (burn_go)
            burn_cnt <= burn_cnt + CW'(1);
         fuses_done <= (burn_cnt == CW'(OBITS));
      end
   end

   // ==========================================================
   // active configuration, read from fuses once after reset
   logic             cfg_load;  // high on the first cycle after reset
   logic [OBITS-1:0] cfg;       // configuration in force

   // a burn takes effect only at the next reset release
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         cfg_load <= 1'h1;
         cfg      <= '0;
      end
      else
      begin
         cfg_load <= 1'h0;
         if (cfg_load)
            cfg <= fuse;
      end
   end

   wire [1:0] mode_bits = {cfg[masr_pkg::POS_MODE_ONE], cfg[masr_pkg::POS_MODE_ZERO]};

   // ==========================================================
   // status outputs
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         fast_mode             <= 1'h0;
         quad_mode_en          <= 1'h0;
         prog_mode             <= 1'h0;
         otp_user              <= '0;
         unique_die_identifier <= '0;
      end
      else
      begin
         fast_mode    <= speed_s;  // low or open is slow
         quad_mode_en <= (mode_bits == masr_pkg::MODE_QUAD);
         prog_mode    <= ~in_normal;
         otp_user     <= cfg[masr_pkg::POS_USER_LSB +: masr_pkg::OTP_USER_BITS];
         unique_die_identifier <= cfg[masr_pkg::POS_DIE_ID_LSB +: masr_pkg::DIE_ID_BITS];
      end
   end

   // ==========================================================
   // open-drain field flags: enable low pulls the pin low
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         field_up_flag_n_o      <= 1'h0;
         field_up_flag_n_oe_n   <= 1'h1;
         field_down_flag_n_o    <= 1'h0;
         field_down_flag_n_oe_n <= 1'h1;
      end
      else
      begin
         field_up_flag_n_o      <= 1'h0;
         field_up_flag_n_oe_n   <= ~field_up;
         field_down_flag_n_o    <= 1'h0;
         field_down_flag_n_oe_n <= ~field_down;
      end
   end

   // ==========================================================
   // pulse width output, half rate set by a configuration bit
   masr_pwm #(
      .ABITS    (ABITS),
      .STEPS    (masr_pkg::PWM_PERIOD_STEPS),
      .CYC_FAST (masr_pkg::PWM_STEP_CYC_FAST),
      .CYC_SLOW (masr_pkg::PWM_STEP_CYC_SLOW)
   ) u_pwm (
      .clk       (clk),
      .rst       (rst),
      .angle     (angle),
      .half_rate (cfg[masr_pkg::POS_PWM_HALF]),
      .pwm_out   (pwm_out)
   );

endmodule : masr_readout
`default_nettype wire

// ---- masr_pkg.sv ----
// constants, field layouts and mode states of the angle serial readout
// assumes a 100 MHz system clock; every other file but the synchroniser reads it as masr_pkg::name
package masr_pkg;

   // ==========================================================
   // clock
   localparam int CLK_PERIOD_NS = 10;   // system clock period

   // ==========================================================
   // serial word layout
   localparam int ANGLE_BITS      = 12;    // angle field width
   localparam int ANGLE_POSITIONS = 4096;  // codes per revolution
   localparam int WORD_BITS       = 18;    // readout word width
   localparam int SEP_BITS        = 1;     // separator after each word
   localparam int FRAME_BITS      = WORD_BITS + SEP_BITS;
   localparam int POS_ANGLE_LSB   = 6;     // angle sits in [17:6]
   localparam int POS_OFFSET_DONE = 5;     // offset compensation finished
   localparam int POS_OVERFLOW    = 4;     // angle engine overflow
   localparam int POS_LINEARITY   = 3;     // linearity alarm
   localparam int POS_FIELD_UP    = 2;     // field_up_bit
   localparam int POS_FIELD_DOWN  = 1;     // field_down_bit
   localparam int POS_PARITY      = 0;     // even parity over [17:1]
   localparam logic SEP_VALUE     = 1'h0;  // level of the separator bit

   // ==========================================================
   // pulse width output timing
   localparam int PWM_PERIOD_STEPS = 1025;  // steps per period
   localparam int PWM_MIN_HIGH     = 1;     // high steps at angle zero
   localparam int PWM_STEP_NS_FAST = 1000;  // 1 us per step
   localparam int PWM_STEP_NS_SLOW = 2000;  // 2 us per step
   localparam int PWM_STEP_CYC_FAST = PWM_STEP_NS_FAST / CLK_PERIOD_NS;
   localparam int PWM_STEP_CYC_SLOW = PWM_STEP_NS_SLOW / CLK_PERIOD_NS;

   // ==========================================================
   // one-time-programmable configuration layout
   localparam int OTP_BITS       = 54;  // whole configuration chain
   localparam int OTP_USER_BITS  = 21;  // user part, shifted in first
   localparam int POS_USER_LSB   = 33;  // user part sits in [53:33]
   localparam int POS_MODE_ONE   = 53;  // output_mode_bit_one
   localparam int POS_MODE_ZERO  = 52;  // output_mode_bit_zero
   localparam int POS_PWM_HALF   = 51;  // pulse output at half rate
   localparam int DIE_ID_BITS    = 20;  // unique_die_identifier width
   localparam int POS_DIE_ID_LSB = 0;   // die id sits in [19:0]
   localparam logic [1:0] MODE_QUAD = 2'h1;  // quadrature output code
   localparam logic [OTP_BITS-1:0] FUSE_BLANK = '0;  // unburnt fuses

   // ==========================================================
   // operating modes
   typedef enum logic [1:0] {
      MASR_NORMAL,     // readout active
      MASR_PROG_LOAD,  // configuration shifting in
      MASR_PROG_BURN   // fuses being blown
   } masr_mode_t;

endpackage : masr_pkg

// ---- masr_sync.sv ----
// two-flop synchroniser for a vector of independent pin levels
// assumes each bit is a slow level; bits are not coherent with each other
`timescale 1ns/100ps
`default_nettype none

module masr_sync #(
   parameter int               WIDTH   = 1,   // number of levels
   parameter logic [WIDTH-1:0] RST_VAL = '0   // idle level of each pin
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst,
   // levels
   input  wire logic [WIDTH-1:0] async_in,
   output var  logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta;  // first stage, read only by the second

   // ==========================================================
   // elaboration check
   if (WIDTH < 1)
   begin : g_bad_width
      $error("masr_sync needs at least one bit");
   end

   // ==========================================================
   // two stages
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         meta     <= RST_VAL;
         sync_out <= RST_VAL;
      end
      else
      begin
         meta     <= async_in;
         sync_out <= meta;
      end
   end

endmodule : masr_sync
`default_nettype wire

// ---- masr_pwm.sv ----
// pulse width output: high time follows the angle, fixed step count
// assumes the angle input is on the same clock; latched once per period
`timescale 1ns/100ps
`default_nettype none

module masr_pwm #(
   parameter int ABITS     = masr_pkg::ANGLE_BITS,        // angle width
   parameter int STEPS     = masr_pkg::PWM_PERIOD_STEPS,  // steps per period
   parameter int CYC_FAST  = masr_pkg::PWM_STEP_CYC_FAST, // cycles per step
   parameter int CYC_SLOW  = masr_pkg::PWM_STEP_CYC_SLOW  // half-rate step
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst,
   // control
   input  wire logic [ABITS-1:0] angle,
   input  wire logic             half_rate,
   // output
   output var  logic             pwm_out
);

   localparam int SW = $clog2(STEPS + 1);     // step counter width
   localparam int PW = $clog2(CYC_SLOW + 1);  // prescaler width
   localparam int HW = SW - 1;                // high-steps field width

   logic [PW-1:0] pre;      // cycles within one step
   logic [SW-1:0] step;     // step within period
   logic [SW-1:0] high;     // high steps for this period
   wire  [PW-1:0] pre_end = half_rate ? PW'(CYC_SLOW - 1) : PW'(CYC_FAST - 1);
   wire           tick    = (pre == pre_end);
   wire           wrap    = tick && (step == SW'(STEPS - 1));
   wire  [SW-1:0] next_high = SW'(masr_pkg::PWM_MIN_HIGH)
                            + SW'(angle[ABITS-1 -: HW]);

   // ==========================================================
   // elaboration check
   if (CYC_FAST < 1 || CYC_SLOW < CYC_FAST || ABITS < HW)
   begin : g_bad_cfg
      $error("masr_pwm timing or width out of range");
   end

   // ==========================================================
   // prescaler, step counter and output level
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         pre     <= '0;
         // first period is cut to one step so the angle is latched soon after reset
         step    <= SW'(STEPS - 1);
         high    <= SW'(masr_pkg::PWM_MIN_HIGH);
         pwm_out <= 1'h0;
      end
      else
      begin
         pre <= tick ? '0 : pre + PW'(1);
         if (wrap)
         begin
            step <= '0;
            high <= next_high;  // new angle only at period start
         end
         else if (tick)
         begin
            step <= step + SW'(1);
         end
         pwm_out <= wrap ? 1'h1 : ((tick ? step + SW'(1) : step) < high);
      end
   end

endmodule : masr_pwm
`default_nettype wire

// ---- masr_readout_assertions.sv ----
// checker for the angle serial readout, bound to the top module's ports
// assumes one clock domain with a synchronous active-high reset
`timescale 1ns/100ps
`default_nettype none

module masr_readout_assertions #(
   parameter int ABITS = masr_pkg::ANGLE_BITS,  // angle width
   parameter int OBITS = masr_pkg::OTP_BITS     // chain length
) (
   // clock and reset
   input wire logic             clk,
   input wire logic             rst,
   // watched inputs
   input wire logic [ABITS-1:0] angle,
   input wire logic             field_up,
   input wire logic             field_down,
   input wire logic             select_n,
   input wire logic             speed_sel,
   // watched outputs
   input wire logic             data_out,
   input wire logic             data_oe_n,
   input wire logic             field_up_flag_n_o,
   input wire logic             field_up_flag_n_oe_n,
   input wire logic             field_down_flag_n_o,
   input wire logic             field_down_flag_n_oe_n,
   input wire logic             fast_mode,
   input wire logic             quad_mode_en,
   input wire logic             prog_mode,
   input wire logic [masr_pkg::OTP_USER_BITS-1:0] otp_user
);
   // ==========
   // clocking
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   // a select fall while readout is allowed
   sequence s_sel_fall;
      $fell(select_n) ##0 !prog_mode;
   endsequence

   // ==========
   // assertions
   a_up_flag_follow:
      assert property (!$past(rst) |-> field_up_flag_n_oe_n == !$past(field_up))
      else $error("field up flag wrong");
   a_down_flag_follow:
      assert property (!$past(rst) |-> field_down_flag_n_oe_n == !$past(field_down))
      else $error("field down flag wrong");
   a_flags_pull_low:
      assert property (!field_up_flag_n_o && !field_down_flag_n_o)
      else $error("flag drive level wrong");
   a_msb_first:
      assert property (s_sel_fall |-> ##[3:5] (!data_oe_n && data_out == angle[ABITS-1]))
      else $error("first bit not angle msb");
   a_desel_release:
      assert property (select_n [*8] |-> data_oe_n)
      else $error("data driven while deselected");
   a_sel_drive:
      assert property ((!select_n && !prog_mode) [*6] |-> !data_oe_n)
      else $error("data not driven while selected");
   a_prog_stays:
      assert property (prog_mode |=> prog_mode)
      else $error("programming mode left without reset");
   a_prog_quiet:
      assert property (prog_mode |-> data_oe_n)
      else $error("data driven while programming");
   a_quad_decode:
      assert property (quad_mode_en == ({otp_user[20], otp_user[19]} == masr_pkg::MODE_QUAD))
      else $error("quadrature enable wrong");
   a_fast_follow:
      assert property (speed_sel [*5] |-> fast_mode)
      else $error("fast mode not taken");
endmodule : masr_readout_assertions

bind masr_readout masr_readout_assertions #(.ABITS(ABITS), .OBITS(OBITS)) chk_i (
   .clk, .rst, .angle, .field_up, .field_down, .select_n, .speed_sel, .data_out,
   .data_oe_n, .field_up_flag_n_o, .field_up_flag_n_oe_n, .field_down_flag_n_o,
   .field_down_flag_n_oe_n, .fast_mode, .quad_mode_en, .prog_mode, .otp_user
);
`default_nettype wire

// ---- masr_host.sv ----
// host model: drives the serial pins, reads frames and programs fuses
// assumes a 125 ns serial clock that stands low outside frames
`timescale 1ns/100ps
`default_nettype none

module masr_host (
   // pins driven by the host
   output var logic sclk,
   output var logic select_n,
   output var logic prog_in,
   output var logic prog_burn_level,
   // pins read by the host
   input wire logic data_out,
   input wire logic data_oe_n
);
   localparam real HALF = 62.5;  // half serial clock period in ns
   // chain modelled without its filter network, so its clock limit does not bind here
   logic seen;                   // level read off the data wire

   // idle pins: select pulled up, the rest pulled down
   initial
   begin
      sclk = 1'h0;
      select_n = 1'h1;
      prog_in = 1'h0;
      prog_burn_level = 1'h0;
      seen = 1'h0;
   end

   // one serial clock pulse
   task automatic pulse();
      #(HALF) sclk = 1'h1;
      #(HALF) sclk = 1'h0;
   endtask : pulse

   // read n bits msb first while feeding an upstream frame; a released
   // wire reads as the inverse of the last level
   task automatic read_bits(input int n, input logic [18:0] up, output logic [37:0] q);
      q = '0;
      select_n = 1'h0;
      #(2*HALF);
      for (int i = 0; i < n; i++)
      begin
         seen = data_oe_n ? !seen : data_out;
         q[37-i] = seen;
         prog_in = (i < 19) ? up[18-i] : 1'h0;
         pulse();
      end
      prog_in = 1'h0;
      select_n = 1'h1;
      #(2*HALF);
   endtask : read_bits

   // enter programming, shift the chain, then blow the fuses
   task automatic prog_cfg(input logic [masr_pkg::OTP_BITS-1:0] cfg);
      select_n = 1'h0;
      #(2*HALF) prog_in = 1'h1;
      #(2*HALF) select_n = 1'h1;
      #(2*HALF);
      for (int i = 53; i >= 0; i--)
      begin
         prog_in = cfg[i];
         pulse();
      end
      prog_burn_level = 1'h1;
      #(2*HALF);
      repeat (54) pulse();
      #(4*HALF) prog_burn_level = 1'h0;
      prog_in = 1'h0;
   endtask : prog_cfg
endmodule : masr_host
`default_nettype wire

// ---- masr_readout_tb.sv ----
// self-checking bench for the angle serial readout
// assumes the host model and the bound checker are compiled alongside
`timescale 1ns/100ps
`default_nettype none

module masr_readout_tb;
   // ==========
   // signals
   logic        clk, rst, offset_done, overflow, linearity_alarm, field_up, field_down;
   logic        speed_sel;
   logic [11:0] angle;
   wire logic   sclk, select_n, prog_in, prog_burn_level, data_out, data_oe_n;
   wire logic   fu_o, fu_oe_n, fd_o, fd_oe_n, pwm_out, fast_mode, quad_mode_en;
   wire logic   prog_mode, fuses_done;
   wire logic [20:0] otp_user;
   wire logic [19:0] die_id;
   int          err_total = 0;
   int          checked = 0;
   int          n;
   logic [37:0] q;
   logic [18:0] up;
   logic [4:0]  fl;
   logic [53:0] cfg;

   // ==========
   // design and host
   masr_readout masr_readout_i (.clk(clk), .rst(rst), .angle(angle),
      .offset_done(offset_done), .overflow(overflow), .linearity_alarm(linearity_alarm),
      .field_up(field_up), .field_down(field_down), .sclk(sclk), .select_n(select_n),
      .prog_in(prog_in), .prog_burn_level(prog_burn_level), .speed_sel(speed_sel),
      .data_out(data_out), .data_oe_n(data_oe_n), .field_up_flag_n_o(fu_o),
      .field_up_flag_n_oe_n(fu_oe_n), .field_down_flag_n_o(fd_o),
      .field_down_flag_n_oe_n(fd_oe_n), .pwm_out(pwm_out), .fast_mode(fast_mode),
      .quad_mode_en(quad_mode_en), .prog_mode(prog_mode), .fuses_done(fuses_done),
      .otp_user(otp_user), .unique_die_identifier(die_id));
   masr_host masr_host_i (.sclk(sclk), .select_n(select_n), .prog_in(prog_in),
      .prog_burn_level(prog_burn_level), .data_out(data_out), .data_oe_n(data_oe_n));

   // 100 MHz clock
   initial
   begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end

   // wait k edges, then step just past the edge
   task automatic tick(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask : tick

   // compare one value and count it
   task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
      checked++;
      if (seen !== exp)
      begin
         err_total++;
         $display("wrong value %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask : check

   // print the counts and the verdict, then stop
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : finish_test

   // wait for a period start, then count the cycles the pulse output stays high
   task automatic pwm_high(output int w);
      w = 0;
      while (pwm_out !== 1'h1 && w < 1000)
      begin
         tick(1);
         w++;
      end
      w = 0;
      while (pwm_out === 1'h1 && w < 20000)
      begin
         tick(1);
         w++;
      end
   endtask : pwm_high

   // hang guard
   initial
   begin
      repeat (60000) @(posedge clk);
      err_total++;
      finish_test();
   end

   // ==========
   // tests
   initial
   begin
      rst = 1'h1;
      angle = 12'h0FF;
      {offset_done, overflow, linearity_alarm, field_up, field_down} = 5'h00;
      speed_sel = 1'h1;
      tick(12);
      check("data_oe_n reset", data_oe_n, 1'h1);
      rst = 1'h0;
      $display("test reset done");
      // high time: one step plus one per four angle codes
      pwm_high(n);
      check("pwm high", n, 64 * masr_pkg::PWM_STEP_CYC_FAST);
      speed_sel = 1'h0;
      tick(6);
      check("fast_mode", fast_mode, 1'h0);
      $display("test pwm done");
      // two frames with upstream data behind them
      for (int t = 0; t < 2; t++)
      begin
         angle = t ? 12'h3F1 : 12'hA5C;
         fl = t ? 5'h09 : 5'h16;
         up = t ? 19'h5A5A2 : 19'h2C3D1;
         {offset_done, overflow, linearity_alarm, field_up, field_down} = fl;
         tick(3);
         check("up flag", fu_oe_n, !fl[1]);
         check("down flag", fd_oe_n, !fl[0]);
         masr_host_i.read_bits(38, up, q);
         check("frame", q, {angle, fl, ^{angle, fl}, 1'h0, up});
         tick(8);
         check("data_oe_n idle", data_oe_n, 1'h1);
         $display("test readout %0d done", t);
      end
      // program, then apply after a reset
      angle = 12'h0FF;
      cfg = {2'h1, 1'h1, 18'h2B3C5, 13'h0A5B, 20'hC3A5E};
      masr_host_i.prog_cfg(cfg);
      tick(4);
      check("prog_mode", prog_mode, 1'h1);
      check("fuses_done", fuses_done, 1'h1);
      check("quad early", quad_mode_en, 1'h0);
      rst = 1'h1;
      tick(3);
      rst = 1'h0;
      tick(4);
      check("prog_mode after", prog_mode, 1'h0);
      check("otp_user", otp_user, cfg[53:33]);
      check("die id", die_id, cfg[19:0]);
      check("quad_mode_en", quad_mode_en, 1'h1);
      pwm_high(n);
      check("pwm half rate", n, 64 * masr_pkg::PWM_STEP_CYC_SLOW);
      $display("test program done");
      finish_test();
   end
endmodule : masr_readout_tb
`default_nettype wire
